// *** core/uaar_top.sv ***
// receive address filter with apb register file
// Notes on behaviour
// - multiproc bit enables address recognition
// - address frames flag only on own or broadcast address
// - 8-bit mode uses stop bit as marker
// - 8-bit mode needs match and valid stop
// - accept own masked or broadcast address
// - shift-register mode ignores multiproc bit
// - mask zeros make address bits don't-care
// - each station compares under its own mask
// - address and mask reset to zero
// - multiproc filtering active in 9-bit modes
// - store received ninth bit in 9-bit modes
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module uaar_top
  import uaar_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // frame from the receive shifter, same clock
  input wire logic frame_valid_i,
  input wire uaar_pkg::uaar_frame_s frame_i,
  // outputs
  output logic rx_complete_flag_o,
  output logic irq_o
);
  import uaar_pkg::*;

  uaar_state_e state_q;
  logic [7:0] addr_q;
  logic [7:0] mask_q;
  logic [7:0] sctl_q;
  logic [7:0] rxdata_q;
  logic [IRQ_W-1:0] ists_q;
  logic [IRQ_W-1:0] imsk_q;
  uaar_frame_s frm_q;
  logic [31:0] prdata_q;
  logic hit;
  logic [1:0] mode;
  logic filt_on;
  logic accept;
  logic stop_bad;
  logic wr;
  logic rxc_set;

  function automatic logic sel(input logic [11:0] a, input logic [7:0] i);
    sel = (a[1:0] == 2'h0) && (a[11:2] == {2'h0, i});
  endfunction : sel

  assign wr = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~(sel(paddr_i, IDX_STATION_ADDRESS)
    | sel(paddr_i, IDX_STATION_ADDRESS_MASK) | sel(paddr_i, IDX_SERIAL_CONTROL)
    | sel(paddr_i, IDX_IRQ_STATUS) | sel(paddr_i, IDX_IRQ_MASK)
    | sel(paddr_i, IDX_RX_DATA));
  assign prdata_o = prdata_q;

  assign mode = {sctl_q[SC_MODE_LO], sctl_q[SC_MODE_HI]};
  // mode 0 never filters, whatever the multiproc bit says
  assign filt_on = sctl_q[SC_MP_EN] && (mode != MODE_SHIFT);

  uaar_match #(
    .W(8)
  ) u_match (
    .rx_byte_i(frm_q.data),
    .addr_i(addr_q),
    .mask_i(mask_q),
    .bcast_i(BCAST_ADDR),
    .hit_o(hit)
  );

  // in 8-bit mode ninth carries the stop bit
  assign stop_bad = (mode == MODE_UART8) && !frm_q.ninth;
  always_comb begin
    if (!filt_on) begin
      accept = !stop_bad || mode != MODE_UART8;
    end else begin
      // marker one = address frame; data frames dropped
      accept = frm_q.ninth && hit;
    end
  end

  // frame pipeline
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= UAAR_IDLE;
      frm_q <= '0;
    end else begin
      case (state_q)
        UAAR_IDLE: begin
          if (frame_valid_i) begin
            frm_q <= frame_i;
            state_q <= UAAR_EVAL;
          end
        end
        UAAR_EVAL: state_q <= UAAR_POST;
        UAAR_POST: state_q <= UAAR_IDLE;
        default: state_q <= UAAR_IDLE;
      endcase
    end
  end

  assign rxc_set = (state_q == UAAR_EVAL) && accept;

  // station registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q <= RST_ADDR;
      mask_q <= RST_MASK;
    end else if (wr) begin
      if (sel(paddr_i, IDX_STATION_ADDRESS)) addr_q <= pwdata_i[7:0];
      if (sel(paddr_i, IDX_STATION_ADDRESS_MASK)) mask_q <= pwdata_i[7:0];
    end
  end

  // serial control; hardware set beats software clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sctl_q <= 8'h00;
      rxdata_q <= 8'h00;
    end else begin
      if (wr && sel(paddr_i, IDX_SERIAL_CONTROL)) begin
        sctl_q <= pwdata_i[7:0];
      end
      if (rxc_set) begin
        sctl_q[SC_RXC] <= 1'b1;
        rxdata_q <= frm_q.data;
        if (mode != MODE_SHIFT) sctl_q[SC_NINTH] <= frm_q.ninth;
      end
    end
  end

  // interrupt status, write one to clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ists_q <= '0;
      imsk_q <= '0;
    end else begin
      if (wr && sel(paddr_i, IDX_IRQ_STATUS)) begin
        ists_q <= ists_q & ~pwdata_i[IRQ_W-1:0];
      end
      if (wr && sel(paddr_i, IDX_IRQ_MASK)) imsk_q <= pwdata_i[IRQ_W-1:0];
      if (rxc_set) ists_q[IRQ_RXC] <= 1'b1;
      if (state_q == UAAR_EVAL && stop_bad) ists_q[IRQ_FERR] <= 1'b1;
    end
  end

  // read data
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_q <= '0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_q <= '0;
      if (sel(paddr_i, IDX_STATION_ADDRESS)) prdata_q <= {24'h0, addr_q};
      if (sel(paddr_i, IDX_STATION_ADDRESS_MASK)) prdata_q <= {24'h0, mask_q};
      if (sel(paddr_i, IDX_SERIAL_CONTROL)) prdata_q <= {24'h0, sctl_q};
      if (sel(paddr_i, IDX_IRQ_STATUS)) prdata_q <= {30'h0, ists_q};
      if (sel(paddr_i, IDX_IRQ_MASK)) prdata_q <= {30'h0, imsk_q};
      if (sel(paddr_i, IDX_RX_DATA)) prdata_q <= {24'h0, rxdata_q};
    end
  end

  assign rx_complete_flag_o = sctl_q[SC_RXC];
  assign irq_o = |(ists_q & imsk_q);

  // assertions
  sequence s_eval;
    state_q == UAAR_EVAL;
  endsequence

  sequence s_take;
    state_q == UAAR_IDLE && frame_valid_i;
  endsequence

  property p_shift_no_filter;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eval and mode == MODE_SHIFT and sctl_q[SC_MP_EN] |-> rxc_set;
  endproperty
  a_shift_no_filter: assert property (p_shift_no_filter)
    else $error("filter active in shift mode");

  property p_mismatch_no_flag;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eval and filt_on and !hit and !rx_complete_flag_o
      and !(wr && sel(paddr_i, IDX_SERIAL_CONTROL)) |=> !rx_complete_flag_o;
  endproperty
  a_mismatch_no_flag: assert property (p_mismatch_no_flag)
    else $error("flag set on foreign address");

  property p_match_flag;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eval and filt_on and hit and frm_q.ninth |=> rx_complete_flag_o;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("matching address not flagged");

  property p_data_dropped;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eval and filt_on and !frm_q.ninth |-> !rxc_set;
  endproperty
  a_data_dropped: assert property (p_data_dropped)
    else $error("data frame passed filter");

  property p_mask_dontcare;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    ((frm_q.data & mask_q) == (addr_q & mask_q)) |-> hit;
  endproperty
  a_mask_dontcare: assert property (p_mask_dontcare)
    else $error("masked compare failed");

  property p_ninth_store;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rxc_set and mode != MODE_SHIFT
      |=> sctl_q[SC_NINTH] == $past(frm_q.ninth);
  endproperty
  a_ninth_store: assert property (p_ninth_store)
    else $error("ninth bit not stored");

  property p_pipe;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_take |=> s_eval ##1 state_q == UAAR_POST;
  endproperty
  a_pipe: assert property (p_pipe)
    else $error("frame pipeline stalled");

  property p_irq;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rxc_set && imsk_q[IRQ_RXC] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq not raised");

  property p_stop_no_flag;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eval and mode == MODE_UART8 and !frm_q.ninth |-> !rxc_set;
  endproperty
  a_stop_no_flag: assert property (p_stop_no_flag)
    else $error("frame with bad stop bit flagged");

  property p_stop_ferr;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eval and mode == MODE_UART8 and !frm_q.ninth |=> ists_q[IRQ_FERR];
  endproperty
  a_stop_ferr: assert property (p_stop_ferr)
    else $error("framing error not recorded");

  property p_filter_off_pass;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eval and !sctl_q[SC_MP_EN] and (mode != MODE_UART8 || frm_q.ninth)
      |-> rxc_set;
  endproperty
  a_filter_off_pass: assert property (p_filter_off_pass)
    else $error("frame dropped with filter off");

  property p_flag_sticky;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rx_complete_flag_o and !(wr && sel(paddr_i, IDX_SERIAL_CONTROL))
      |=> rx_complete_flag_o;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag cleared without software write");

  property p_broadcast;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eval and filt_on and frm_q.ninth and frm_q.data == BCAST_ADDR
      and mask_q != '0 |-> rxc_set;
  endproperty
  a_broadcast: assert property (p_broadcast)
    else $error("broadcast address not accepted");

  property p_ninth_kept;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rxc_set and mode == MODE_SHIFT
      and !(wr && sel(paddr_i, IDX_SERIAL_CONTROL))
      |=> $stable(sctl_q[SC_NINTH]);
  endproperty
  a_ninth_kept: assert property (p_ninth_kept)
    else $error("ninth bit changed in shift mode");

  property p_exact;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eval and filt_on and &mask_q and frm_q.data != addr_q
      and frm_q.data != BCAST_ADDR |-> !rxc_set;
  endproperty
  a_exact: assert property (p_exact)
    else $error("foreign address accepted under full mask");
endmodule : uaar_top

// *** common/uaar_pkg.sv ***
// package: register map, fields and types of the address filter
package uaar_pkg;
  // printed offsets are not multiples of four: indices, byte addr = 4*index
  localparam logic [7:0] IDX_STATION_ADDRESS = 8'hA9;
  localparam logic [7:0] IDX_STATION_ADDRESS_MASK = 8'hB9;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hC0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hC1;
  localparam logic [7:0] IDX_RX_DATA = 8'hC2;
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] BCAST_ADDR = 8'hFF;
  // serial_control field positions
  localparam int SC_MODE_HI = 6;
  localparam int SC_MODE_LO = 7;
  localparam int SC_MP_EN = 5;
  localparam int SC_NINTH = 2;
  localparam int SC_RXC = 0;
  // interrupt status bits
  localparam int IRQ_RXC = 0;
  localparam int IRQ_FERR = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  typedef enum logic [1:0] {
    UAAR_IDLE = 2'b00,
    UAAR_EVAL = 2'b01,
    UAAR_POST = 2'b10
  } uaar_state_e;
  // one received frame from the shifter
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } uaar_frame_s;
endpackage : uaar_pkg

// *** core/uaar_match.sv ***
// masked address comparator for one station
`timescale 1ns/100ps
module uaar_match #(
  parameter int W = 8
) (
  // compare operands
  input wire logic [W-1:0] rx_byte_i,
  input wire logic [W-1:0] addr_i,
  input wire logic [W-1:0] mask_i,
  input wire logic [W-1:0] bcast_i,
  // result
  output logic hit_o
);
  logic [W-1:0] bit_ok;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // zero mask bit makes this bit don't-care
      assign bit_ok[g] = ~mask_i[g] | (rx_byte_i[g] == addr_i[g]);
    end
  endgenerate
  // broadcast: the mask-formed broadcast pattern also accepts
  assign hit_o = (&bit_ok) | (((rx_byte_i | ~mask_i) & bcast_i) == bcast_i
                 && mask_i != '0 && &bcast_i);
endmodule : uaar_match

// *** bench/uaar_frame_src.sv ***
// line partner model: hands received frames to the filter
`timescale 1ns/100ps
module uaar_frame_src
  import uaar_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // received frame
  output logic frame_valid_o,
  output uaar_pkg::uaar_frame_s frame_o
);
  initial begin
    frame_valid_o = 1'b0;
    frame_o = '0;
  end
  // one-cycle pulse; payload inverted after so stale data never matches
  task automatic send(input logic [7:0] d, input logic n);
    @(posedge clk_sys_i);
    frame_valid_o <= 1'b1;
    frame_o <= '{data: d, ninth: n};
    @(posedge clk_sys_i);
    frame_valid_o <= 1'b0;
    frame_o <= '{data: ~d, ninth: ~n};
  endtask : send
endmodule : uaar_frame_src

// *** bench/uart_address_recognition_bench.sv ***
// self-checking bench for the receive address filter
`timescale 1ns/100ps
module uart_address_recognition_bench;
  import uaar_pkg::*;
  localparam logic [11:0] A_SA = {2'b00, IDX_STATION_ADDRESS, 2'b00};
  localparam logic [11:0] A_SM = {2'b00, IDX_STATION_ADDRESS_MASK, 2'b00};
  localparam logic [11:0] A_SC = {2'b00, IDX_SERIAL_CONTROL, 2'b00};
  localparam logic [11:0] A_ST = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_IM = {2'b00, IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_RD = {2'b00, IDX_RX_DATA, 2'b00};
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic frame_valid_i;
  uaar_frame_s frame_i;
  logic rx_complete_flag_o;
  logic irq_o;
  logic [31:0] rd_q;
  logic err_q;
  int err_total = 0;
  int n_checks = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  uaar_frame_src i_src (
    .clk_sys_i(clk_sys_i),
    .frame_valid_o(frame_valid_i),
    .frame_o(frame_i)
  );
  uaar_top i_dut (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .frame_valid_i(frame_valid_i),
    .frame_i(frame_i),
    .rx_complete_flag_o(rx_complete_flag_o),
    .irq_o(irq_o)
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      close_out();
    end else begin
      rd_q = prdata_o;
      err_q = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask : apb

  // writing control clears the flag, then one frame and its verdict
  task automatic run_frame(input logic [7:0] sc, input logic [7:0] d,
                           input logic n, input logic e);
    apb(1'b1, A_SC, {24'h000000, sc});
    apb(1'b1, A_ST, 32'h00000001);
    i_src.send(d, n);
    repeat (3) @(posedge clk_sys_i);
    #1;
    check({31'h0, rx_complete_flag_o}, {31'h0, e});
    check({31'h0, irq_o}, {31'h0, e});
    apb(1'b0, A_SC, 32'h00000000);
    if (e && sc[7]) check(rd_q & 32'h00000005, {29'h0, n, 2'b01});
    apb(1'b0, A_RD, 32'h00000000);
    if (e) check(rd_q, {24'h000000, d});
  endtask : run_frame

  initial begin
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    apb(1'b0, A_SA, 32'h00000000);
    check(rd_q, 32'h00000000);
    apb(1'b0, A_SM, 32'h00000000);
    check(rd_q, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000);
    check({31'h0, err_q}, 32'h00000001);
    apb(1'b1, A_SA, 32'h00000056);
    apb(1'b1, A_SM, 32'h000000FC);
    apb(1'b1, A_IM, 32'h00000001);
    apb(1'b0, A_SA, 32'h00000000);
    check(rd_q, 32'h00000056);
    run_frame(8'hA0, 8'h57, 1'b1, 1'b1);
    run_frame(8'hE0, 8'h5A, 1'b1, 1'b0);
    run_frame(8'hA0, 8'h56, 1'b0, 1'b0);
    run_frame(8'hE0, 8'hFF, 1'b1, 1'b1);
    run_frame(8'h60, 8'h54, 1'b1, 1'b1);
    run_frame(8'h60, 8'h54, 1'b0, 1'b0);
    apb(1'b0, A_ST, 32'h00000000);
    check(rd_q & 32'h00000002, 32'h00000002);
    run_frame(8'h20, 8'h33, 1'b0, 1'b1);
    run_frame(8'h80, 8'h33, 1'b0, 1'b1);
    apb(1'b1, A_SM, 32'h000000FF);
    run_frame(8'hA0, 8'h57, 1'b1, 1'b0);
    run_frame(8'hA0, 8'h56, 1'b1, 1'b1);
    apb(1'b1, A_IM, 32'h00000000);
    #1;
    check({31'h0, irq_o}, 32'h00000000);
    apb(1'b1, A_ST, 32'h00000001);
    apb(1'b0, A_ST, 32'h00000000);
    check(rd_q & 32'h00000001, 32'h00000000);
    close_out();
  end
endmodule : uart_address_recognition_bench
